// [rfs_map.vh]
`ifndef RFS_MAP_VH
`define RFS_MAP_VH
// Register offsets (byte addresses on the core's data bus)
`define RFS_ADDR_ROW_LOW     16'h0762
`define RFS_ADDR_ROW_HIGH    16'h0764
`define RFS_ADDR_CONTROL     16'h0920
`define RFS_ADDR_KEY         16'h9920
`define RFS_ADDR_IRQ_STATUS  16'h0922
`define RFS_ADDR_IRQ_MASK    16'h0924
// Control register fields
`define RFS_CTL_START_BIT    15
`define RFS_CTL_ALLOW_BIT    14
`define RFS_CTL_FAULT_BIT    13
`define RFS_CTL_TIMED_BIT    8
`define RFS_CTL_OPSEL_MSB    6
`define RFS_CTL_RESET        16'h0000
`define RFS_CTL_ERASE_BIT    6
// Unlock keys
`define RFS_KEY_FIRST        8'h55
`define RFS_KEY_SECOND       8'haa
// Row geometry
`define RFS_ROW_WORDS        32
`define RFS_ROW_INDEX_W      5
// Operation time, in microseconds, and the clock rate in MHz
`define RFS_OP_TIME_US       2000
`define RFS_CLK_MHZ          10
`define RFS_OP_CYCLES        (`RFS_OP_TIME_US * `RFS_CLK_MHZ)
// Interrupt status bits
`define RFS_IRQ_DONE_BIT     0
`define RFS_IRQ_FAULT_BIT    1
`endif

// [rfs_latch_bank.v]
`timescale 1ns/1ns
// Panel write latches: one 24-bit word per slot of the row
module rfs_latch_bank #(
    parameter WORDS = 32,
    parameter IDX_W = 5
) (
    input  wire             mclk,
    input  wire             sys_rst,
    input  wire             low_we,
    input  wire             high_we,
    input  wire [IDX_W-1:0] idx,
    input  wire [15:0]      wdata,
    input  wire [IDX_W-1:0] rd_idx,
    output reg  [23:0]      rd_word
);
    reg [23:0] latch_mem [0:WORDS-1];

    ////////////////////////////////////////////////////////////////////
    // Latch writes; high writes keep only the low byte of the source
    always @(posedge mclk) begin
        if (low_we) begin
            latch_mem[idx] <= {latch_mem[idx][23:16], wdata};
        end
        if (high_we) begin
            latch_mem[idx] <= {wdata[7:0], latch_mem[idx][15:0]};
        end
    end

    // Registered read port for the array sequencer
    always @(posedge mclk) begin
        if (sys_rst) begin
            rd_word <= 24'h000000;
        end else begin
            rd_word <= latch_mem[rd_idx];
        end
    end
endmodule // rfs_latch_bank

// [rfs_row_sequencer.v]
`timescale 1ns/1ns
`include "rfs_map.vh"
// Function
// - Erase program flash one 32-word row
// - Row address split low and page byte
// - Keys 0x55 then 0xAA before start
// - Start bit 15 launches the operation
// - 96 latch bytes filled by table writes
// - High-byte latch write keeps low byte
// - Start bit clears itself when finished
// - Operation takes 2 ms, core stalls
// - Row address captures last table address
// - Key register is write only
module rfs_row_sequencer #(
    parameter OP_CYCLES = `RFS_OP_CYCLES
) (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        tbl_wr_low,
    input  wire        tbl_wr_high,
    input  wire [15:0] effective_address,
    input  wire [7:0]  table_page,
    input  wire [15:0] tbl_wdata,
    input  wire        op_abort,
    output wire        core_stall,
    output reg         flash_erase,
    output reg         flash_program,
    output reg  [23:0] flash_addr,
    output wire [23:0] flash_wdata,
    output reg         flash_word_we,
    output wire        irq
);
    // States, one-hot
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_LOAD = 4'b0010;
    localparam [3:0] ST_BUSY = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;

    // Key tracker states, one-hot; any stray write drops back to the
    // first state, so the two keys must sit right before the start
    localparam [2:0] KEY_NONE  = 3'b001;
    localparam [2:0] KEY_FIRST = 3'b010;
    localparam [2:0] KEY_BOTH  = 3'b100;

    // Length of the timed phase in clocks, at the timer's width; it
    // must be at least one or the timed phase runs for 2^32 clocks
    localparam [31:0] OP_CYC = OP_CYCLES;

    ////////////////////////////////////////////////////////////////////
    // Control, address and sequencing state
    reg  [15:0] row_address_low_reg;
    reg  [7:0]  row_address_high_reg;
    reg         start_reg;
    reg         write_allow_reg;
    reg         write_fault_reg;
    reg         timed_write_indicator_reg;
    reg  [6:0]  operation_select_reg;
    reg  [2:0]  key_state_reg;
    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg  [31:0] timer_reg;
    reg  [4:0]  word_idx_reg;
    reg  [1:0]  irq_status_reg;
    reg  [1:0]  irq_mask_reg;
    reg         op_is_erase_reg;

    // Decoded strobes, state taps and the latch read path
    wire        op_start;
    wire        op_end;
    wire        wr_ctl;
    wire        wr_key;
    wire        any_tbl;
    wire [4:0]  latch_idx;
    wire [23:0] latch_word;
    wire        in_load;
    wire        in_busy;

    ////////////////////////////////////////////////////////////////////
    // Address decode, used for both writes and reads; kept as one
    // function so every register sees the same full compare
    function hit;
        input [15:0] a;
        input [15:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    assign wr_ctl  = reg_wr & hit(reg_addr, `RFS_ADDR_CONTROL);
    assign wr_key  = reg_wr & hit(reg_addr, `RFS_ADDR_KEY);
    assign any_tbl = tbl_wr_low | tbl_wr_high;

    // Launch only when the keys were the two writes right before and
    // write-allow is set in the same control write; a stale allow bit
    // from an older write is not enough, so a stray start stays inert
    assign op_start = wr_ctl & reg_wdata[`RFS_CTL_START_BIT] & ~start_reg
                      & (key_state_reg == KEY_BOTH)
                      & reg_wdata[`RFS_CTL_ALLOW_BIT];

    // Done lasts one cycle: it clears the start bit and raises the event
    assign op_end = (state_reg == ST_DONE);

    // One-hot state taps shared by the timer and the array strobes
    assign in_load = (state_reg == ST_LOAD);
    assign in_busy = (state_reg == ST_BUSY);

    // Core is held while an operation is under way; the stall is the
    // start bit itself, so the core resumes as the start bit reads clear
    assign core_stall = start_reg;

    ////////////////////////////////////////////////////////////////////
    // Key tracker: any bus write other than the expected key breaks
    // the sequence, so the keys must be the last writes before start.
    // Reads and table writes leave it alone, so polling is harmless
    always @(posedge mclk) begin
        if (sys_rst) begin
            key_state_reg <= KEY_NONE;
        end else if (reg_wr) begin
            if (wr_key && reg_wdata[7:0] == `RFS_KEY_FIRST) begin
                key_state_reg <= KEY_FIRST;
            end else if (wr_key && reg_wdata[7:0] == `RFS_KEY_SECOND
                         && key_state_reg == KEY_FIRST) begin
                key_state_reg <= KEY_BOTH;
            end else begin
                key_state_reg <= KEY_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Row address registers: direct writes, or capture of table writes.
    // Frozen while busy, since the array takes its row from here for the
    // whole operation
    always @(posedge mclk) begin
        if (sys_rst) begin
            row_address_low_reg  <= 16'h0000;
            row_address_high_reg <= 8'h00;
        end else if (any_tbl && !start_reg) begin
            row_address_low_reg  <= effective_address;
            row_address_high_reg <= table_page;
        end else if (reg_wr && !start_reg) begin
            if (hit(reg_addr, `RFS_ADDR_ROW_LOW)) begin
                row_address_low_reg <= reg_wdata;
            end
            if (hit(reg_addr, `RFS_ADDR_ROW_HIGH)) begin
                row_address_high_reg <= reg_wdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register; allow and select fields frozen while busy so a running cycle
    // cannot be retargeted. The write fault is sticky: an abort in the
    // same cycle as a clearing write leaves it set. The timed indicator
    // marks a cycle that ran to its end and is cleared by a new launch
    always @(posedge mclk) begin
        if (sys_rst) begin
            start_reg                 <= 1'b0;
            write_allow_reg           <= 1'b0;
            write_fault_reg           <= 1'b0;
            timed_write_indicator_reg <= 1'b0;
            operation_select_reg      <= 7'h00;
        end else begin
            if (op_start) begin
                start_reg <= 1'b1;
            end else if (op_end || (start_reg && op_abort)) begin
                start_reg <= 1'b0;
            end
            if (start_reg && op_abort) begin
                write_fault_reg <= 1'b1;
            end else if (wr_ctl && !reg_wdata[`RFS_CTL_FAULT_BIT]) begin
                write_fault_reg <= 1'b0;
            end
            if (op_end) begin
                timed_write_indicator_reg <= 1'b1;
            end else if (op_start) begin
                timed_write_indicator_reg <= 1'b0;
            end
            if (wr_ctl && !start_reg) begin
                write_allow_reg      <= reg_wdata[`RFS_CTL_ALLOW_BIT];
                operation_select_reg <= reg_wdata[`RFS_CTL_OPSEL_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operation sequencer: erase runs the whole time, programming
    // first walks the 32 latch words into the array. An abort from
    // either working state returns straight to idle; the start bit and
    // the fault flag follow it in the control register
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (op_start) begin
                    state_next = reg_wdata[`RFS_CTL_ERASE_BIT] ? ST_BUSY : ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (op_abort) begin
                    state_next = ST_IDLE;
                end else if (word_idx_reg == 5'h1f) begin
                    state_next = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (op_abort) begin
                    state_next = ST_IDLE;
                end else if (timer_reg == OP_CYC - 32'h1) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State, cycle timer and latch walk index. The timer runs only in
    // the timed phase, so the walk does not eat into the programming
    // time and a program lasts 32 cycles longer than an erase
    always @(posedge mclk) begin
        if (sys_rst) begin
            state_reg       <= ST_IDLE;
            timer_reg       <= 32'h0;
            word_idx_reg    <= 5'h00;
            op_is_erase_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (op_start) begin
                timer_reg       <= 32'h0;
                word_idx_reg    <= 5'h00;
                op_is_erase_reg <= reg_wdata[`RFS_CTL_ERASE_BIT];
            end else begin
                if (in_busy) begin
                    timer_reg <= timer_reg + 32'h1;
                end
                if (in_load) begin
                    word_idx_reg <= word_idx_reg + 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Array strobes; the row base drops the five word-index bits
    // (two address units per word) so a whole row is hit. Address and
    // word leave together, one cycle behind the walk index, so the
    // array sees them paired on every write strobe
    always @(posedge mclk) begin
        if (sys_rst) begin
            flash_erase   <= 1'b0;
            flash_program <= 1'b0;
            flash_addr    <= 24'h000000;
            flash_word_we <= 1'b0;
        end else begin
            flash_erase   <= in_busy & op_is_erase_reg;
            flash_program <= in_busy & ~op_is_erase_reg;
            flash_word_we <= in_load;
            flash_addr    <= {row_address_high_reg, row_address_low_reg[15:6],
                              in_load ? word_idx_reg : 5'h00,
                              1'b0};
        end
    end

    // Word slot within the row from the table pointer; bit 0 is the
    // byte lane and the bits above pick a row, which the latches ignore
    assign latch_idx = effective_address[5:1];

    // Latch bank, read in step with the walk index; table writes are
    // refused while busy, so the walk reads a settled row
    rfs_latch_bank #(
        .WORDS (`RFS_ROW_WORDS),
        .IDX_W (`RFS_ROW_INDEX_W)
    ) u_latch (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .low_we  (tbl_wr_low & ~start_reg),
        .high_we (tbl_wr_high & ~start_reg),
        .idx     (latch_idx),
        .wdata   (tbl_wdata),
        .rd_idx  (word_idx_reg),
        .rd_word (latch_word)
    );
    assign flash_wdata = latch_word;

    ////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, cleared by reading; a new event in the
    // clearing cycle survives. Only done and fault exist, so status and
    // mask are two bits wide
    always @(posedge mclk) begin
        if (sys_rst) begin
            irq_status_reg <= 2'b00;
            irq_mask_reg   <= 2'b00;
        end else begin
            irq_status_reg <= ((reg_rd && hit(reg_addr, `RFS_ADDR_IRQ_STATUS))
                               ? 2'b00 : irq_status_reg)
                              | {start_reg & op_abort, op_end};
            if (reg_wr && hit(reg_addr, `RFS_ADDR_IRQ_MASK)) begin
                irq_mask_reg <= reg_wdata[1:0];
            end
        end
    end
    // Level output, high while an unmasked event is pending
    assign irq = |(irq_status_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe and zero otherwise, so a
    // bus that ORs its slaves together stays clean. The key has no read
    // path at all: its value lives only in the tracker
    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `RFS_ADDR_ROW_LOW:    reg_rdata <= row_address_low_reg;
                `RFS_ADDR_ROW_HIGH:   reg_rdata <= {8'h00, row_address_high_reg};
                `RFS_ADDR_CONTROL:    reg_rdata <= {start_reg, write_allow_reg,
                                                    write_fault_reg, 4'h0,
                                                    timed_write_indicator_reg,
                                                    1'b0, operation_select_reg};
                `RFS_ADDR_IRQ_STATUS: reg_rdata <= {14'h0000, irq_status_reg};
                `RFS_ADDR_IRQ_MASK:   reg_rdata <= {14'h0000, irq_mask_reg};
                default:              reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule // rfs_row_sequencer

// [rfs_row_sequencer_props.sv]
`timescale 1ns/1ns
`include "rfs_map.vh"
// Port-level timing checks on the row sequencer
module rfs_seq_props #(
    parameter OP_CYCLES = 20
) (
    input wire        mclk,
    input wire        sys_rst,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        op_abort,
    input wire        core_stall,
    input wire        flash_erase,
    input wire        flash_program,
    input wire        flash_word_we
);
    reg [15:0] run_reg;
    reg        abt_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Stall run length; aborted runs are flagged so the length check skips them
    always @(posedge mclk) begin
        run_reg <= (sys_rst || !core_stall) ? 16'h0000 : run_reg + 16'h0001;
        abt_reg <= (!sys_rst && core_stall) ? (abt_reg | op_abort) : 1'b0;
    end
    ////////////////////////////////////////
    property p_start_cause;
        $rose(core_stall) |-> $past(reg_wr) && $past(reg_wdata[15:14]) == 2'b11
            && $past(reg_addr) == `RFS_ADDR_CONTROL;
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("stall without launch");
    property p_erase_sel;
        $rose(core_stall) |=> flash_erase == $past(reg_wdata[6], 2);
    endproperty
    a_erase_sel: assert property (p_erase_sel) else $error("erase select wrong");
    property p_run_len;
        $fell(core_stall) && !abt_reg |->
            run_reg == OP_CYCLES + 1 || run_reg == OP_CYCLES + 33;
    endproperty
    a_run_len: assert property (p_run_len) else $error("stall length wrong");
    property p_walk;
        $rose(flash_word_we) |-> core_stall && !flash_erase;
    endproperty
    a_walk: assert property (p_walk) else $error("latch walk outside program");
    property p_op_busy;
        (flash_erase || flash_program || flash_word_we) |-> core_stall || $past(core_stall);
    endproperty
    a_op_busy: assert property (p_op_busy) else $error("flash active while idle");
    property p_done_quiet;
        $fell(core_stall) |=> !flash_erase && !flash_program;
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("flash active after end");
    property p_key_read;
        $past(reg_rd) && $past(reg_addr) == `RFS_ADDR_KEY |-> reg_rdata == 16'h0000;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key readable");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_reset_quiet;
        $fell(sys_rst) |-> !core_stall && !flash_erase && reg_rdata == 16'h0000;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("busy out of reset");
endmodule // rfs_seq_props

bind rfs_row_sequencer rfs_seq_props #(.OP_CYCLES(OP_CYCLES)) u_props (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_abort(op_abort),
    .core_stall(core_stall), .flash_erase(flash_erase), .flash_program(flash_program),
    .flash_word_we(flash_word_we)
);

// [rfs_core_model.sv]
`timescale 1ns/1ns
`include "rfs_map.vh"
// Core side: register accesses, table writes and abort
module rfs_core_model (
    input  wire        mclk,
    input  wire [15:0] reg_rdata,
    output reg  [15:0] reg_addr,
    output reg  [15:0] reg_wdata,
    output reg         reg_wr,
    output reg         reg_rd,
    output reg         tbl_wr_low,
    output reg         tbl_wr_high,
    output reg  [15:0] effective_address,
    output reg  [7:0]  table_page,
    output reg  [15:0] tbl_wdata,
    output reg         op_abort
);
    // Idle bus at time zero
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, op_abort} = 35'h0;
        {tbl_wr_low, tbl_wr_high, effective_address, table_page, tbl_wdata} = 42'h0;
    end
    // Strobes stay up until the next call, so writes run back to back
    task bus(input w, input r, input [15:0] a, input [15:0] d);
        begin
            reg_wr <= w;
            reg_rd <= r;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge mclk);
        end
    endtask
    // Read data stands only in the cycle after the strobe; taken at its closing edge
    task rd(input [15:0] a, output [15:0] q);
        begin
            bus(1'b0, 1'b1, a, 16'h0000);
            reg_rd <= 1'b0;
            @(posedge mclk);
            q = reg_rdata;
        end
    endtask
    task tbl(input lo, input hi, input [15:0] ea, input [7:0] pg, input [15:0] d);
        begin
            tbl_wr_low <= lo;
            tbl_wr_high <= hi;
            effective_address <= ea;
            table_page <= pg;
            tbl_wdata <= d;
            @(posedge mclk);
        end
    endtask
    // Nothing else touches the bus between keys and start, as with interrupts held off
    task launch(input [7:0] k1, input [7:0] k2, input [15:0] ctl);
        begin
            bus(1'b1, 1'b0, `RFS_ADDR_KEY, {8'h00, k1});
            bus(1'b1, 1'b0, `RFS_ADDR_KEY, {8'h00, k2});
            bus(1'b1, 1'b0, `RFS_ADDR_CONTROL, ctl);
            bus(1'b0, 1'b0, 16'h0000, 16'h0000);
            bus(1'b0, 1'b0, 16'h0000, 16'h0000);
        end
    endtask
    task abort;
        begin
            op_abort <= 1'b1;
            @(posedge mclk);
            op_abort <= 1'b0;
        end
    endtask
endmodule // rfs_core_model

// [rfs_row_sequencer_tb.sv]
`timescale 1ns/1ns
`include "rfs_map.vh"
// Short operation time keeps the run small
module rfs_row_sequencer_tb;
    localparam OPC = 20;
    reg         mclk;
    reg         sys_rst;
    wire [15:0] reg_addr, reg_wdata, reg_rdata, effective_address, tbl_wdata;
    wire [7:0]  table_page;
    wire [23:0] flash_addr, flash_wdata;
    wire        reg_wr, reg_rd, tbl_wr_low, tbl_wr_high, op_abort, core_stall;
    wire        flash_erase, flash_program, flash_word_we, irq;
    integer     n_errors, comparisons, cyc, n, we_cnt, we_bad;
    reg  [15:0] q, i;
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    rfs_row_sequencer #(.OP_CYCLES(OPC)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tbl_wr_low(tbl_wr_low), .tbl_wr_high(tbl_wr_high),
        .effective_address(effective_address), .table_page(table_page),
        .tbl_wdata(tbl_wdata), .op_abort(op_abort), .core_stall(core_stall),
        .flash_erase(flash_erase), .flash_program(flash_program), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_word_we(flash_word_we), .irq(irq));
    rfs_core_model core (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .tbl_wr_low(tbl_wr_low),
        .tbl_wr_high(tbl_wr_high), .effective_address(effective_address),
        .table_page(table_page), .tbl_wdata(tbl_wdata), .op_abort(op_abort));
    ////////////////////////////////////////
    // Latch words seen by the array in slot order nn: low word 0x10nn,
    // high byte nn, address 0x6000 + 2nn
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            finish_test;
        end
        if (flash_word_we === 1'b1) begin
            we_cnt = we_cnt + 1;
            if (flash_wdata[15:8] !== 8'h10 || flash_wdata[23:16] !== flash_wdata[7:0]
                || flash_wdata[7:0] !== we_cnt - 1
                || flash_addr !== 24'h006000 + 2 * (we_cnt - 1))
                we_bad = we_bad + 1;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Edges until the stall is seen clear, sampled at each edge, bounded
    task wait_idle;
        begin
            n = 0;
            while (core_stall !== 1'b0 && n < 500) begin
                @(posedge mclk);
                n = n + 1;
            end
        end
    endtask
    task finish_test;
        begin
            $display("errors=%0d comparisons=%0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    ////////////////////////////////////////
    task t_regs;
        begin
            core.rd(`RFS_ADDR_CONTROL, q);
            chk(q, 16'h0000);
            core.bus(1'b1, 1'b0, `RFS_ADDR_ROW_LOW, 16'habcd);
            core.bus(1'b1, 1'b0, `RFS_ADDR_ROW_HIGH, 16'h0034);
            core.bus(1'b1, 1'b0, `RFS_ADDR_KEY, 16'h0055);
            core.rd(`RFS_ADDR_ROW_LOW, q);
            chk(q, 16'habcd);
            core.rd(`RFS_ADDR_ROW_HIGH, q);
            chk(q[7:0], 8'h34);
            core.rd(`RFS_ADDR_KEY, q);
            chk(q, 16'h0000);
            core.rd(16'h0100, q);
            chk(q, 16'h0000);
        end
    endtask
    task t_capture;
        begin
            core.tbl(1'b1, 1'b0, 16'h6040, 8'h12, 16'h0000);
            core.tbl(1'b0, 1'b0, 16'h0000, 8'h00, 16'h0000);
            core.rd(`RFS_ADDR_ROW_LOW, q);
            chk(q, 16'h6040);
            core.rd(`RFS_ADDR_ROW_HIGH, q);
            chk(q[7:0], 8'h12);
        end
    endtask
    task t_badkey;
        begin
            core.launch(8'haa, 8'h55, 16'hc041);
            chk(core_stall, 1'b0);
            core.launch(8'h55, 8'haa, 16'h8041);
            chk(core_stall, 1'b0);
            core.rd(`RFS_ADDR_CONTROL, q);
            chk(q[15], 1'b0);
        end
    endtask
    task t_erase;
        begin
            core.bus(1'b1, 1'b0, `RFS_ADDR_IRQ_MASK, 16'h0003);
            core.bus(1'b1, 1'b0, `RFS_ADDR_CONTROL, 16'h4041);
            core.launch(8'h55, 8'haa, 16'hc041);
            chk(core_stall, 1'b1);
            chk({flash_erase, flash_program}, 2'b10);
            chk(flash_addr, 24'h126040);
            wait_idle;
            chk(n, OPC);
            core.rd(`RFS_ADDR_CONTROL, q);
            chk(q[15], 1'b0);
            chk(irq, 1'b1);
            core.rd(`RFS_ADDR_IRQ_STATUS, q);
            chk(q[0], 1'b1);
            chk(irq, 1'b0);
        end
    endtask
    task t_program;
        begin
            core.bus(1'b1, 1'b0, `RFS_ADDR_CONTROL, 16'h4001);
            core.bus(1'b0, 1'b0, 16'h0000, 16'h0000);
            for (i = 16'h0000; i < 16'h0020; i = i + 16'h0001) begin
                core.tbl(1'b1, 1'b0, 16'h6000 + (i << 1), 8'h00, 16'h1000 + i);
                core.tbl(1'b0, 1'b1, 16'h6000 + (i << 1), 8'h00, 16'hff00 + i);
            end
            core.tbl(1'b0, 1'b0, 16'h0000, 8'h00, 16'h0000);
            we_cnt = 0;
            we_bad = 0;
            core.launch(8'h55, 8'haa, 16'hc001);
            wait_idle;
            chk(n, OPC + 32);
            chk(we_cnt, 32);
            chk(we_bad, 0);
        end
    endtask
    task t_abort;
        begin
            core.launch(8'h55, 8'haa, 16'hc041);
            core.abort;
            wait_idle;
            core.rd(`RFS_ADDR_CONTROL, q);
            core.rd(`RFS_ADDR_CONTROL, q);
            chk(q[15:13], 3'b011);
            core.rd(`RFS_ADDR_IRQ_STATUS, q);
            chk(q[1], 1'b1);
            core.bus(1'b1, 1'b0, `RFS_ADDR_CONTROL, 16'h4041);
            core.rd(`RFS_ADDR_CONTROL, q);
            chk(q[13], 1'b0);
        end
    endtask
    // Reset for five cycles, then each scenario in turn
    initial begin
        n_errors = 0;
        comparisons = 0;
        cyc = 0;
        we_cnt = 0;
        we_bad = 0;
        sys_rst = 1'b1;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs;
        t_capture;
        t_badkey;
        t_erase;
        t_program;
        t_abort;
        finish_test;
    end
endmodule // rfs_row_sequencer_tb
